//--- rtl/sarc_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none

// approximation register, one bit per conversion-clock edge
module sarc_bit_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic conv_fall,
  input wire logic conv_edge,
  input wire logic comp_in,
  output logic [11:0] word,
  output logic done
);

  logic [11:0] sar_reg;
  logic [11:0] trial_reg;
  logic [1:0] fall_cnt_reg;
  logic run_reg;
  logic armed_reg;

  // ----------------------------------------------------------------
  // sequencing from msb to lsb
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sar_reg <= sarc_pkg::RESULT_RST;
      trial_reg <= sarc_pkg::RESULT_RST;
      fall_cnt_reg <= 2'h0;
      run_reg <= 1'b0;
      armed_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        sar_reg <= sarc_pkg::RESULT_RST;
        trial_reg <= 12'h800;
        fall_cnt_reg <= 2'h0;
        run_reg <= 1'b1;
        armed_reg <= 1'b0;
      end else if (run_reg) begin
        if (!armed_reg) begin
          if (conv_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 2'h1;
            if (fall_cnt_reg == 2'(sarc_pkg::MSB_FALL_EDGES - 1)) begin
              armed_reg <= 1'b1;
              sar_reg <= comp_in ? trial_reg : sar_reg;
              trial_reg <= trial_reg >> 1;
            end
          end
        end else if (conv_edge) begin
          sar_reg <= comp_in ? (sar_reg | trial_reg) : sar_reg;
          trial_reg <= trial_reg >> 1;
          if (trial_reg == 12'h001) begin
            run_reg <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

  // straight binary, one code per fs/4096
  assign word = sar_reg;

endmodule

`default_nettype wire

//--- rtl/sarc_pkg.sv
`default_nettype none

package sarc_pkg;

  // ------------------------------------------------------------------
  // result format
  // ------------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int BUS_W = 12;
  localparam int FULL_SCALE_CODES = 4096;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [3:0] LOW_ZERO_NIBBLE = 4'h0;

  // ------------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------------
  localparam int MSB_FALL_EDGES = 2;
  localparam int SYNC_STAGES = 2;

  // bus control bundle, active-low strobes
  typedef struct packed {
    logic chip_sel_n;
    logic read_n;
    logic high_byte_select;
  } sarc_ctrl_t;

  // pin driver bundle
  typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe;
  } sarc_pins_t;

endpackage

`default_nettype wire

//--- rtl/sarc_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - clock out pin is inverted clock in
// - no duty cycle needed on clock in
// - result is 12-bit straight binary
// - start when select, read, byte select low
// - starts ignored while converting
// - busy low while converting, plus one cycle after latch
// - prefetch read starts conversion, returns old result
// - result right justified on bus
// - byte select steers low or high byte
// - high byte: lines 7-4 low, 3-0 top bits
// - top four lines always carry top bits
// - falling select and read start, busy low
// - previous result shown during wait conversion
// - latch updated before busy returns high
// - low byte taken at end of first read
// - second read high byte, no start
// - msb after second falling edge, then per edge
// - finished word copied to output latch
// - prefetch read returns previous result, restarts
module sarc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic high_byte_select,
  input wire logic conv_clk_in,
  input wire logic comp_in,
  output logic conv_clk_out,
  output logic busy_n,
  output logic [11:0] result_bus_pins,
  output logic [11:0] result_bus_oe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  sarc_pkg::sarc_ctrl_t ctrl_meta_reg;
  sarc_pkg::sarc_ctrl_t ctrl_reg;
  logic clk_meta_reg;
  logic clk_sync_reg;
  logic clk_prev_reg;
  logic comp_meta_reg;
  logic comp_sync_reg;

  // two flops on every control and comparator input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_meta_reg <= '1;
      ctrl_reg <= '1;
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      ctrl_meta_reg <= {chip_sel_n, read_n, high_byte_select};
      ctrl_reg <= ctrl_meta_reg;
      comp_meta_reg <= comp_in;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // conversion clock sampled, only levels used so duty cycle is free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_meta_reg <= conv_clk_in;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
    end
  end

  logic conv_fall;
  logic conv_edge;
  assign conv_fall = clk_prev_reg & ~clk_sync_reg;
  assign conv_edge = clk_prev_reg ^ clk_sync_reg;

  // ----------------------------------------------------------------
  // oscillator output
  // ----------------------------------------------------------------
  // inverse of the synchronised clock in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_clk_out <= 1'b1;
    end else begin
      conv_clk_out <= ~clk_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // start detection
  // ----------------------------------------------------------------
  logic read_active;
  logic start_cond;
  logic start_prev_reg;
  logic converting_reg;
  logic start_pulse;
  logic eng_done;
  logic [11:0] eng_word;

  assign read_active = ~ctrl_reg.chip_sel_n & ~ctrl_reg.read_n;
  assign start_cond = read_active & ~ctrl_reg.high_byte_select;
  // rising edge of the combined start term, ignored while converting
  assign start_pulse = start_cond & ~start_prev_reg & ~converting_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_cond;
    end
  end

  // conversion in progress flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converting_reg <= 1'b0;
    end else if (start_pulse) begin
      converting_reg <= 1'b1;
    end else if (eng_done) begin
      converting_reg <= 1'b0;
    end
  end

  sarc_bit_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_pulse),
    .conv_fall(conv_fall),
    .conv_edge(conv_edge),
    .comp_in(comp_sync_reg),
    .word(eng_word),
    .done(eng_done)
  );

  // ----------------------------------------------------------------
  // result latch and busy
  // ----------------------------------------------------------------
  logic [11:0] result_reg;

  // latch keeps old result during conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= sarc_pkg::RESULT_RST;
    end else if (eng_done) begin
      result_reg <= eng_word;
    end
  end

  // busy follows one cycle after latch, so data is settled first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_n <= 1'b1;
    end else if (start_pulse) begin
      busy_n <= 1'b0;
    end else if (!converting_reg) begin
      busy_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output multiplexer and drivers
  // ----------------------------------------------------------------
  sarc_pkg::sarc_pins_t pins_next;

  // byte steering, previous result until latch updates
  always_comb begin
    pins_next.data = result_reg;
    if (ctrl_reg.high_byte_select) begin
      pins_next.data[7:4] = sarc_pkg::LOW_ZERO_NIBBLE;
      pins_next.data[3:0] = result_reg[11:8];
    end
    pins_next.data[11:8] = result_reg[11:8];
    pins_next.oe = read_active ? 12'hfff : 12'h000;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_bus_pins <= sarc_pkg::RESULT_RST;
      result_bus_oe <= 12'h000;
    end else begin
      result_bus_pins <= pins_next.data;
      result_bus_oe <= pins_next.oe;
    end
  end

endmodule

`default_nettype wire

//--- test/sarc_conv_source.sv
`timescale 1ns/1ps
`default_nettype none

// crystal and comparator stand-in on the analog side of the converter
module sarc_conv_source (
  input wire logic run,
  input wire logic level,
  output logic conv_clk,
  output logic comp
);
  // uneven phases, clock still until run is set
  initial begin
    conv_clk = 1'b0;
    forever begin
      #(conv_clk ? 40 : 72);
      if (run) begin
        conv_clk = !conv_clk;
      end
    end
  end
  // verdict held for a whole conversion
  assign comp = level;
endmodule

`default_nettype wire

//--- test/sarc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// watches the converter control pins
module sarc_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic high_byte_select,
  input wire logic conv_clk_in,
  input wire logic comp_in,
  input wire logic conv_clk_out,
  input wire logic busy_n,
  input wire logic [11:0] result_bus_pins,
  input wire logic [11:0] result_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  // start term of the three controls
  assign go = !chip_sel_n && !read_n && !high_byte_select;
  a_clk_out_inverse: assert property (
    $stable(conv_clk_in)[*6] |-> conv_clk_out != conv_clk_in) else $error("clock out wrong");
  a_start_busy: assert property (
    $rose(go) && busy_n |-> ##[1:4] !busy_n) else $error("start not seen");
  a_busy_cause: assert property (
    $fell(busy_n) |-> $past(go, 2)) else $error("busy without start");
  a_hbs_no_start: assert property (
    high_byte_select[*5] && busy_n |=> busy_n) else $error("start with high byte");
  a_idle_float: assert property (
    (chip_sel_n || read_n)[*5] |-> result_bus_oe == 12'h000) else $error("bus not released");
  a_read_drives: assert property (
    (!chip_sel_n && !read_n)[*5] |-> result_bus_oe == 12'hfff) else $error("bus not driven");
  a_high_byte_map: assert property (
    (high_byte_select && !chip_sel_n && !read_n)[*5] |-> result_bus_pins[7:4] == 4'h0
    && result_bus_pins[3:0] == result_bus_pins[11:8]) else $error("high byte map wrong");
  a_top_held: assert property (
    !busy_n && $past(!busy_n) && result_bus_oe[11] |-> $stable(result_bus_pins[11:8]))
    else $error("data moved in conversion");
  a_busy_span: assert property (
    $fell(busy_n) |-> !busy_n[*8] ##[42:392] $rose(busy_n)) else $error("busy length wrong");
endmodule

bind sarc_top sarc_monitor mon (.clk, .rst_n, .chip_sel_n, .read_n, .high_byte_select,
  .conv_clk_in, .comp_in, .conv_clk_out, .busy_n, .result_bus_pins, .result_bus_oe);

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, rst_n, cs_n, rd_n, hbs, run, lvl, m, cki, cmp, busy_n;
  logic [11:0] pins, oe, last, nw, q;
  int n_fail, check_count, i, k;
  sarc_conv_source src (.run, .level(lvl), .conv_clk(cki), .comp(cmp));
  sarc_top uut (.clk, .rst_n, .chip_sel_n(cs_n), .read_n(rd_n), .high_byte_select(hbs),
    .conv_clk_in(cki), .comp_in(cmp), .conv_clk_out(), .busy_n,
    .result_bus_pins(pins), .result_bus_oe(oe));
  // 8 ns system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  // compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for a busy level
  task automatic wait_busy(input logic lv);
    for (k = 0; k < 400 && busy_n !== lv; k++) @(negedge clk);
    if (k == 400) begin
      n_fail++;
      summarize();
    end
  endtask
  // one bus read, wt keeps it pending through the conversion
  task automatic rd(input logic h, input logic wt);
    cs_n = 1'b0;
    rd_n = 1'b0;
    hbs = h;
    repeat (6) @(negedge clk);
    if (!h) begin
      chk({11'h000, busy_n}, 12'h000);
      chk(pins, last);
    end
    if (wt) begin
      // read held pending until busy returns high, master stalls itself
      wait_busy(1'b1);
      repeat (2) @(negedge clk);
    end
    q = pins;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(oe, 12'h000);
  endtask
  // wait-state and prefetch reads with random comparator verdicts
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    hbs = 1'b0;
    run = 1'b0;
    lvl = 1'b0;
    last = 12'h000;
    n_fail = 0;
    check_count = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b1;
    k = $urandom(60045);
    for (i = 0; i < 10; i++) begin
      lvl = (i < 2) ? i[0] : 1'($urandom);
      m = (i < 4) ? i[0] : 1'($urandom);
      nw = lvl ? 12'hfff : 12'h000;
      if (m) begin
        rd(1'b0, 1'b1);
        chk(q, nw);
        rd(1'b1, 1'b0);
        chk(q, {nw[11:8], 4'h0, nw[11:8]});
        chk({11'h000, busy_n}, 12'h001);
      end else begin
        rd(1'b0, 1'b0);
        wait_busy(1'b1);
      end
      last = nw;
      // over 1 us idle, start phase random against the conversion clock
      repeat (130 + ($urandom % 16)) @(negedge clk);
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule

`default_nettype wire
